//--- common/hpdc_regs.svh
// register offsets, reset values and timing constants of the hub power descriptor bank
`ifndef HPDC_REGS_SVH
`define HPDC_REGS_SVH

// register indices; byte address is four times the index
`define HPDC_IDX_SELF_POWERED_MAX_POWER 12'h00C
`define HPDC_IDX_BUS_POWERED_MAX_POWER 12'h00D
`define HPDC_IDX_SELF_POWERED_CONTROLLER_CURRENT 12'h00E
`define HPDC_IDX_BUS_POWERED_CONTROLLER_CURRENT 12'h00F
`define HPDC_IDX_PORT_POWER_GOOD_DELAY 12'h010
`define HPDC_IDX_LANGUAGE_UPPER_BYTE 12'h011
`define HPDC_IDX_LANGUAGE_LOWER_BYTE 12'h012
`define HPDC_IDX_POWER_MODE_CONTROL 12'h100
`define HPDC_IDX_REPORT_STATUS 12'h101

// reset values
`define HPDC_RST_BYTE 8'h00
`define HPDC_RST_CONTROL 2'h0

// power mode control fields
`define HPDC_CTL_OVERRIDE_BIT 0
`define HPDC_CTL_FORCE_SELF_BIT 1

// report status fields
`define HPDC_STS_CURRENT_LSB 0
`define HPDC_STS_MAX_POWER_LSB 8
`define HPDC_STS_SELF_MODE_BIT 16
`define HPDC_STS_GOOD_BIT 17
`define HPDC_STS_TIMING_BIT 18

// bus responses
`define HPDC_RESP_OKAY 2'h0
`define HPDC_RESP_SLVERR 2'h2

// power-good delay step: 2 ms at a 10 MHz clock
`define HPDC_STEP_TIME_US 2000
`define HPDC_CLK_FREQ_MHZ 10
`define HPDC_STEP_CYCLES (`HPDC_STEP_TIME_US * `HPDC_CLK_FREQ_MHZ)

`endif

//--- common/hpdc_pkg.sv
// types shared by the hub power descriptor bank
package hpdc_pkg;

  // power-good timer states
  typedef enum logic [1:0] {
    HPDC_PG_OFF,
    HPDC_PG_WAIT,
    HPDC_PG_GOOD
  } hpdc_pg_state_t;

  // one configuration byte
  typedef logic [7:0] hpdc_byte_t;

endpackage

//--- logic/hpdc_config.sv
// hub power descriptor configuration bank with axi4-lite access and power-good timer
`timescale 1ns/10ps
`include "hpdc_regs.svh"

module hpdc_config
  import hpdc_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int STEP_CYCLES = `HPDC_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  // axi4-lite write address channel
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data channel
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response channel
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address channel
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data channel
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // powering mode strap pin, high when the hub runs self-powered
  input wire logic self_powered_pin,
  // port power sequencing from the hub core
  input wire logic port_power_start,
  input wire logic port_power_off,
  // descriptor values handed to the hub core
  output logic [7:0] reported_max_power,
  output logic [7:0] reported_controller_current,
  output logic [7:0] power_good_delay,
  output logic [15:0] language_id,
  output logic self_powered_mode,
  output logic port_power_good
);

  // configuration storage
  hpdc_byte_t self_powered_current_field;
  hpdc_byte_t bus_powered_current_field;
  hpdc_byte_t self_powered_silicon_current_field;
  hpdc_byte_t bus_powered_silicon_current_field;
  hpdc_byte_t power_on_delay_field;
  hpdc_byte_t language_upper_field;
  hpdc_byte_t language_lower_field;
  logic [1:0] power_mode_control;

  // write channel holding state
  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [ADDR_W-3:0] wr_index;
  logic [ADDR_W-3:0] rd_index;

  // mode pin synchroniser
  logic mode_sync1;
  logic mode_sync2;
  logic mode_sync3;
  logic pin_self_mode;
  logic next_self_mode;

  // power-good timer
  hpdc_pg_state_t pg_state;
  logic [7:0] steps_left;
  logic [$clog2(STEP_CYCLES+1)-1:0] step_count;
  logic step_tick;

  // read multiplexer
  logic [31:0] next_rdata;
  logic next_rresp_err;

  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign wr_index = aw_addr[ADDR_W-1:2];
  assign rd_index = s_axi_araddr[ADDR_W-1:2];

  // write address channel: accept one address, hold it until the write completes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_full <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end else if (!aw_full && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // write data channel: accept one data beat, independent of the address order
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_wready <= 1'b0;
      w_full <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_full <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_full <= 1'b0;
    end else if (!w_full && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // write response: answers once both halves are in, error for unmapped words
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HPDC_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (wr_index == (ADDR_W-2)'(`HPDC_IDX_SELF_POWERED_MAX_POWER) ||
          wr_index == (ADDR_W-2)'(`HPDC_IDX_BUS_POWERED_MAX_POWER) ||
          wr_index == (ADDR_W-2)'(`HPDC_IDX_SELF_POWERED_CONTROLLER_CURRENT) ||
          wr_index == (ADDR_W-2)'(`HPDC_IDX_BUS_POWERED_CONTROLLER_CURRENT) ||
          wr_index == (ADDR_W-2)'(`HPDC_IDX_PORT_POWER_GOOD_DELAY) ||
          wr_index == (ADDR_W-2)'(`HPDC_IDX_LANGUAGE_UPPER_BYTE) ||
          wr_index == (ADDR_W-2)'(`HPDC_IDX_LANGUAGE_LOWER_BYTE) ||
          wr_index == (ADDR_W-2)'(`HPDC_IDX_POWER_MODE_CONTROL) ||
          wr_index == (ADDR_W-2)'(`HPDC_IDX_REPORT_STATUS)) begin
        s_axi_bresp <= `HPDC_RESP_OKAY;
      end else begin
        s_axi_bresp <= `HPDC_RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HPDC_RESP_OKAY;
    end
  end

  // current figures, stored in 2 ma units; limits are left to software
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      self_powered_current_field <= `HPDC_RST_BYTE;
      bus_powered_current_field <= `HPDC_RST_BYTE;
      self_powered_silicon_current_field <= `HPDC_RST_BYTE;
      bus_powered_silicon_current_field <= `HPDC_RST_BYTE;
    end else if (do_write && w_strb[0]) begin
      if (wr_index == (ADDR_W-2)'(`HPDC_IDX_SELF_POWERED_MAX_POWER)) begin
        self_powered_current_field <= w_data[7:0];
      end else if (wr_index == (ADDR_W-2)'(`HPDC_IDX_BUS_POWERED_MAX_POWER)) begin
        bus_powered_current_field <= w_data[7:0];
      end else if (wr_index == (ADDR_W-2)'(`HPDC_IDX_SELF_POWERED_CONTROLLER_CURRENT)) begin
        self_powered_silicon_current_field <= w_data[7:0];
      end else if (wr_index == (ADDR_W-2)'(`HPDC_IDX_BUS_POWERED_CONTROLLER_CURRENT)) begin
        bus_powered_silicon_current_field <= w_data[7:0];
      end
    end
  end

  // delay, language identifier and mode control bytes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_on_delay_field <= `HPDC_RST_BYTE;
      language_upper_field <= `HPDC_RST_BYTE;
      language_lower_field <= `HPDC_RST_BYTE;
      power_mode_control <= `HPDC_RST_CONTROL;
    end else if (do_write && w_strb[0]) begin
      if (wr_index == (ADDR_W-2)'(`HPDC_IDX_PORT_POWER_GOOD_DELAY)) begin
        power_on_delay_field <= w_data[7:0];
      end else if (wr_index == (ADDR_W-2)'(`HPDC_IDX_LANGUAGE_UPPER_BYTE)) begin
        language_upper_field <= w_data[7:0];
      end else if (wr_index == (ADDR_W-2)'(`HPDC_IDX_LANGUAGE_LOWER_BYTE)) begin
        language_lower_field <= w_data[7:0];
      end else if (wr_index == (ADDR_W-2)'(`HPDC_IDX_POWER_MODE_CONTROL)) begin
        power_mode_control <= w_data[1:0];
      end
    end
  end

  // read data selection by register index
  always_comb begin
    next_rdata = 32'h0000_0000;
    next_rresp_err = 1'b0;
    if (rd_index == (ADDR_W-2)'(`HPDC_IDX_SELF_POWERED_MAX_POWER)) begin
      next_rdata[7:0] = self_powered_current_field;
    end else if (rd_index == (ADDR_W-2)'(`HPDC_IDX_BUS_POWERED_MAX_POWER)) begin
      next_rdata[7:0] = bus_powered_current_field;
    end else if (rd_index == (ADDR_W-2)'(`HPDC_IDX_SELF_POWERED_CONTROLLER_CURRENT)) begin
      next_rdata[7:0] = self_powered_silicon_current_field;
    end else if (rd_index == (ADDR_W-2)'(`HPDC_IDX_BUS_POWERED_CONTROLLER_CURRENT)) begin
      next_rdata[7:0] = bus_powered_silicon_current_field;
    end else if (rd_index == (ADDR_W-2)'(`HPDC_IDX_PORT_POWER_GOOD_DELAY)) begin
      next_rdata[7:0] = power_on_delay_field;
    end else if (rd_index == (ADDR_W-2)'(`HPDC_IDX_LANGUAGE_UPPER_BYTE)) begin
      next_rdata[7:0] = language_upper_field;
    end else if (rd_index == (ADDR_W-2)'(`HPDC_IDX_LANGUAGE_LOWER_BYTE)) begin
      next_rdata[7:0] = language_lower_field;
    end else if (rd_index == (ADDR_W-2)'(`HPDC_IDX_POWER_MODE_CONTROL)) begin
      next_rdata[1:0] = power_mode_control;
    end else if (rd_index == (ADDR_W-2)'(`HPDC_IDX_REPORT_STATUS)) begin
      next_rdata[`HPDC_STS_CURRENT_LSB +: 8] = reported_controller_current;
      next_rdata[`HPDC_STS_MAX_POWER_LSB +: 8] = reported_max_power;
      next_rdata[`HPDC_STS_SELF_MODE_BIT] = self_powered_mode;
      next_rdata[`HPDC_STS_GOOD_BIT] = port_power_good;
      next_rdata[`HPDC_STS_TIMING_BIT] = (pg_state == HPDC_PG_WAIT);
    end else begin
      next_rresp_err = 1'b1;
    end
  end

  // read channel: one read at a time, data registered one cycle after the address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `HPDC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp_err ? `HPDC_RESP_SLVERR : `HPDC_RESP_OKAY;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `HPDC_RESP_OKAY;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // three-stage synchroniser on the powering mode pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_sync1 <= 1'b0;
      mode_sync2 <= 1'b0;
      mode_sync3 <= 1'b0;
    end else begin
      mode_sync1 <= self_powered_pin;
      mode_sync2 <= mode_sync1;
      mode_sync3 <= mode_sync2;
    end
  end

  // pin level is taken only once the last two stages agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_self_mode <= 1'b0;
    end else if (mode_sync2 == mode_sync3) begin
      pin_self_mode <= mode_sync3;
    end
  end

  // software override of the powering mode, otherwise the pin decides
  always_comb begin
    if (power_mode_control[`HPDC_CTL_OVERRIDE_BIT]) begin
      next_self_mode = power_mode_control[`HPDC_CTL_FORCE_SELF_BIT];
    end else begin
      next_self_mode = pin_self_mode;
    end
  end

  // descriptor values for the hub core, chosen by powering mode
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      self_powered_mode <= 1'b0;
      reported_max_power <= `HPDC_RST_BYTE;
      reported_controller_current <= `HPDC_RST_BYTE;
    end else begin
      self_powered_mode <= next_self_mode;
      if (next_self_mode) begin
        reported_max_power <= self_powered_current_field;
        reported_controller_current <= self_powered_silicon_current_field;
      end else begin
        reported_max_power <= bus_powered_current_field;
        reported_controller_current <= bus_powered_silicon_current_field;
      end
    end
  end

  // delay and language identifier handed on as stored
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_good_delay <= `HPDC_RST_BYTE;
      language_id <= 16'h0000;
    end else begin
      power_good_delay <= power_on_delay_field;
      language_id <= {language_upper_field, language_lower_field};
    end
  end

  // 2 ms step divider, restarted with every power-on sequence
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      step_count <= '0;
      step_tick <= 1'b0;
    end else if (port_power_start || pg_state != HPDC_PG_WAIT) begin
      step_count <= '0;
      step_tick <= 1'b0;
    end else if (step_count == ($clog2(STEP_CYCLES+1))'(STEP_CYCLES - 1)) begin
      step_count <= '0;
      step_tick <= 1'b1;
    end else begin
      step_count <= step_count + 1'b1;
      step_tick <= 1'b0;
    end
  end

  // power-good timer: counts the programmed number of 2 ms steps
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pg_state <= HPDC_PG_OFF;
      steps_left <= 8'h00;
      port_power_good <= 1'b0;
    end else if (port_power_off) begin
      pg_state <= HPDC_PG_OFF;
      steps_left <= 8'h00;
      port_power_good <= 1'b0;
    end else if (port_power_start) begin
      port_power_good <= 1'b0;
      steps_left <= power_on_delay_field;
      if (power_on_delay_field == 8'h00) begin
        pg_state <= HPDC_PG_GOOD;
        port_power_good <= 1'b1;
      end else begin
        pg_state <= HPDC_PG_WAIT;
      end
    end else begin
      case (pg_state)
        HPDC_PG_OFF: begin
          port_power_good <= 1'b0;
        end
        HPDC_PG_WAIT: begin
          if (step_tick) begin
            if (steps_left == 8'h01) begin
              pg_state <= HPDC_PG_GOOD;
              port_power_good <= 1'b1;
              steps_left <= 8'h00;
            end else begin
              steps_left <= steps_left - 8'h01;
            end
          end
        end
        HPDC_PG_GOOD: begin
          port_power_good <= 1'b1;
        end
        default: begin
          pg_state <= HPDC_PG_OFF;
          port_power_good <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- tb/hpdc_config_chk.sv
// assertion checker for the hub power descriptor bank
`timescale 1ns/10ps
module hpdc_config_chk #(
  parameter int STEP_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic port_power_start,
  input wire logic port_power_off,
  input wire logic [7:0] power_good_delay,
  input wire logic port_power_good
);
  int cnt;
  logic [7:0] d_lat;
  // cycles since the last accepted power-on start, with the delay then in force
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      d_lat <= 8'h00;
    end else if (port_power_start && !port_power_off) begin
      cnt <= 0;
      d_lat <= power_good_delay;
    end else if (cnt < 100000) begin
      cnt <= cnt + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_block: assert property (p_b_block) else $error("write taken during response");
  property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_r_block: assert property (p_r_block) else $error("read taken during response");
  property p_pg_time;
    $rose(port_power_good) |-> cnt == (d_lat == 8'h00 ? 0 : d_lat * STEP_CYCLES + 1);
  endproperty
  a_pg_time: assert property (p_pg_time) else $error("power good at wrong time");
  property p_pg_zero;
    port_power_start && !port_power_off && power_good_delay == 8'h00 |=> port_power_good;
  endproperty
  a_pg_zero: assert property (p_pg_zero) else $error("zero delay not immediate");
  property p_pg_drop;
    port_power_start && !port_power_off && power_good_delay != 8'h00 |=> !port_power_good;
  endproperty
  a_pg_drop: assert property (p_pg_drop) else $error("restart kept power good");
  property p_pg_off; port_power_off |=> !port_power_good; endproperty
  a_pg_off: assert property (p_pg_off) else $error("power good after off");
endmodule
bind hpdc_config hpdc_config_chk #(.STEP_CYCLES(STEP_CYCLES)) hpdc_config_chk_i (
  .clk(clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .port_power_start(port_power_start), .port_power_off(port_power_off),
  .power_good_delay(power_good_delay), .port_power_good(port_power_good));

//--- tb/hpdc_host_model.sv
// host side model that powers a port and waits the power-on time
`timescale 1ns/10ps
module hpdc_host_model #(
  parameter int STEP_CYCLES = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic go,
  input wire logic halt,
  input wire logic [7:0] delay,
  input wire logic good,
  output logic start,
  output logic off,
  output logic done,
  output logic seen
);
  int wcnt;
  // pulse start once, wait at least the power-on time, then look at power good
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      start <= 1'b0;
      done <= 1'b0;
      seen <= 1'b0;
      wcnt <= -1;
    end else begin
      start <= go;
      done <= 1'b0;
      if (go) begin
        wcnt <= delay * STEP_CYCLES + 3;
      end else if (wcnt > 0) begin
        wcnt <= wcnt - 1;
      end else if (wcnt == 0) begin
        done <= 1'b1;
        seen <= good;
        wcnt <= -1;
      end
    end
  end
  // power removal follows the host request
  assign off = halt;
endmodule

//--- tb/hpdc_config_tb.sv
// self-checking bench for the hub power descriptor bank
`timescale 1ns/10ps
`include "hpdc_regs.svh"
module hpdc_config_tb;
  import hpdc_pkg::*;
  logic clk = 1'b0, reset_n = 1'b0, pin = 1'b0, go = 1'b0, halt = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rdd, seed = 32'hFFC3AC3E, d;
  logic [3:0] ws = 4'h0;
  logic awr, wr_r, bv, arr, rv, selfm, pg, start, off, done, seen;
  logic [1:0] br, rr;
  logic [7:0] rmax, rcur, pgd;
  logic [15:0] lang;
  hpdc_byte_t regs [7] = '{default: 8'h00};
  int fails = 0, n_compared = 0, k, n;
  always #50 clk = ~clk;
  hpdc_config #(.STEP_CYCLES(4)) hpdc_config_i (.clk(clk), .reset_n(reset_n),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .self_powered_pin(pin),
    .port_power_start(start), .port_power_off(off), .reported_max_power(rmax),
    .reported_controller_current(rcur), .power_good_delay(pgd), .language_id(lang),
    .self_powered_mode(selfm), .port_power_good(pg));
  hpdc_host_model #(.STEP_CYCLES(4)) hpdc_host_model_i (.clk(clk), .reset_n(reset_n),
    .go(go), .halt(halt), .delay(pgd), .good(pg), .start(start), .off(off),
    .done(done), .seen(seen));
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [11:0] adr(int i);
    return 12'h030 + 12'(4 * i);
  endfunction
  // byte addresses of the mode control and report status words
  localparam logic [11:0] CTL_A = 12'(`HPDC_IDX_POWER_MODE_CONTROL << 2);
  localparam logic [11:0] STS_A = 12'(`HPDC_IDX_REPORT_STATUS << 2);
  // expected report status word from its fields
  function automatic logic [31:0] sts(logic [7:0] mx, logic [7:0] cur, logic sm, logic g,
                                      logic tm);
    logic [31:0] v;
    v = 32'h0;
    v[`HPDC_STS_CURRENT_LSB +: 8] = cur;
    v[`HPDC_STS_MAX_POWER_LSB +: 8] = mx;
    v[`HPDC_STS_SELF_MODE_BIT] = sm;
    v[`HPDC_STS_GOOD_BIT] = g;
    v[`HPDC_STS_TIMING_BIT] = tm;
    return v;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    $display("fails=%0d n_compared=%0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one write: address and data offered together, bready held until the response
  task automatic wr(logic [11:0] a, logic [31:0] v, logic [3:0] s, logic [1:0] er);
    int i;
    @(posedge clk);
    awa <= a; wd <= v; ws <= s; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if (bv && bry) break;
    end
    bry <= 1'b0;
    if (i == 50) fails++;
    chk(32'(br), 32'(er));
  endtask
  // one read: rready held from the request until the answer is seen
  task automatic rd(logic [11:0] a, logic [31:0] ed, logic [1:0] er);
    int i;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv && rry) break;
    end
    rry <= 1'b0;
    if (i == 50) fails++;
    chk(rdd, ed);
    chk(32'(rr), 32'(er));
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    // reset values of registers and outputs
    for (k = 0; k < 7; k++) rd(adr(k), 32'h0, `HPDC_RESP_OKAY);
    chk(32'({rmax, rcur, pgd}), 32'h0);
    chk(32'(lang), 32'h0);
    // random fills; self-powered figures kept at or below 100 mA
    repeat (3) for (k = 0; k < 7; k++) begin
      seed = lfsr(seed);
      d = seed;
      if (k == 0 || k == 2) d[7:0] = d[7:0] % 8'h33;
      wr(adr(k), d, 4'hF, `HPDC_RESP_OKAY);
      regs[k] = d[7:0];
    end
    for (k = 0; k < 7; k++) rd(adr(k), {24'h0, regs[k]}, `HPDC_RESP_OKAY);
    // strobe off stores nothing; unmapped place is refused
    wr(adr(6), 32'hA5, 4'h0, `HPDC_RESP_OKAY);
    rd(adr(6), {24'h0, regs[6]}, `HPDC_RESP_OKAY);
    wr(12'h200, 32'hFF, 4'hF, `HPDC_RESP_SLVERR);
    rd(12'h200, 32'h0, `HPDC_RESP_SLVERR);
    chk(32'(lang), {16'h0, regs[5], regs[6]});
    chk(32'(pgd), 32'(regs[4]));
    // reported figures follow the powering mode
    for (k = 1; k >= 0; k--) begin
      pin <= k[0];
      repeat (8) @(posedge clk);
      chk(32'(selfm), 32'(k[0]));
      chk(32'(rmax), 32'(k[0] ? regs[0] : regs[1]));
      chk(32'(rcur), 32'(k[0] ? regs[2] : regs[3]));
    end
    // power-on waits: zero delay, then restarts without removing power
    seed = lfsr(seed);
    for (k = 0; k < 3; k++) begin
      d = (k == 0) ? 32'h0 : (k == 1) ? 32'h2 : 32'(seed[1:0]) + 32'h1;
      wr(adr(4), d, 4'hF, `HPDC_RESP_OKAY);
      repeat (2) @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      if (k == 1) rd(STS_A, sts(regs[1], regs[3], 1'b0, 1'b0, 1'b1), `HPDC_RESP_OKAY);
      for (n = 0; n < 200 && !done; n++) @(posedge clk);
      if (n == 200) fails++;
      chk(32'(seen), 32'h1);
    end
    // power removed while the delay still runs: power good never comes
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    halt <= 1'b1;
    for (n = 0; n < 200 && !done; n++) @(posedge clk);
    if (n == 200) fails++;
    chk(32'(seen), 32'h0);
    chk(32'(pg), 32'h0);
    halt <= 1'b0;
    // software override of the powering mode; status word is read only
    wr(CTL_A, 32'h3, 4'hF, `HPDC_RESP_OKAY);
    wr(STS_A, 32'hFFFF_FFFF, 4'hF, `HPDC_RESP_OKAY);
    rd(CTL_A, 32'h3, `HPDC_RESP_OKAY);
    rd(STS_A, sts(regs[0], regs[2], 1'b1, 1'b0, 1'b0), `HPDC_RESP_OKAY);
    pin <= 1'b1;
    wr(CTL_A, 32'h1, 4'hF, `HPDC_RESP_OKAY);
    repeat (8) @(posedge clk);
    chk(32'(selfm), 32'h0);
    chk(32'(rcur), 32'(regs[3]));
    summarize;
  end
  // watchdog well beyond the expected run length
  initial begin
    #(20000 * 100);
    fails++;
    summarize;
  end
endmodule
